// ---- rtl/anptx_register.sv ----
// Behaviour
// - the more-pages bit 15 is copied into the transmitted next-page word.
// - next pages follow the base word only if more-pages is set and the partner is able.
// - reserved bit 14 always reads back as zero.
// - the message-page bit 13 is copied into the transmitted next-page word.
// - the can-comply bit 12 is copied into the transmitted next-page word.
// - the read-only flip bit 11 inverts with each transmitted next-page word.
// - the first next-page word carries the inverse of base word bit 11.
// - the code field bits 10 to 0 go into the code positions of the word.
// - the register sits at management address 7 with mixed access.
`timescale 1ns/10ps
module anptx_register (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic [4:0]  mgmt_addr_i,
  input  wire logic        mgmt_write_i,
  input  wire logic [15:0] mgmt_wdata_i,
  output logic      [15:0] mgmt_rdata_o,
  input  wire logic [15:0] base_word_i,
  input  wire logic        base_sent_i,
  input  wire logic        partner_np_able_i,
  input  wire logic        page_sent_i,
  output logic             next_pages_enable_o,
  output logic      [15:0] next_page_word_o
);

  // ---------------------------------------------------------------
  // local constants
  // ---------------------------------------------------------------

  // reset value kept local so that field slices stay short
  localparam logic [15:0] RESET_VALUE = anptx_pkg::NEXT_PAGE_TRANSMIT_RESET;
  localparam int          CODE_W      = anptx_pkg::CODE_WIDTH;
  localparam int          CODE_HI     = anptx_pkg::CODE_MSB;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------

  // one bit of the reset value
  function automatic logic reset_bit(input int position);
    reset_bit = RESET_VALUE[position];
  endfunction

  // code field out of a full word
  function automatic logic [CODE_W-1:0] code_of(input logic [15:0] value);
    code_of = value[CODE_HI -: CODE_W];
  endfunction

  // one flag out of a full word
  function automatic logic flag_of(input logic [15:0] value, input int position);
    flag_of = value[position];
  endfunction

  // assemble the outgoing word; the reserved bit is forced low here so
  // neither the link nor a management read can ever see it set
  function automatic logic [15:0] compose_word(
    input logic              more_pages,
    input logic              message_page,
    input logic              can_comply,
    input logic              flip,
    input logic [CODE_W-1:0] code_field
  );
    logic [15:0] word;
    word                              = '0;
    word[anptx_pkg::MORE_PAGES_BIT]   = more_pages;
    word[anptx_pkg::RESERVED_BIT]     = 1'b0;
    word[anptx_pkg::MESSAGE_PAGE_BIT] = message_page;
    word[anptx_pkg::CAN_COMPLY_BIT]   = can_comply;
    word[anptx_pkg::FLIP_BIT]         = flip;
    word[CODE_HI -: CODE_W]           = code_field;
    compose_word = word;
  endfunction

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------

  logic hit_w;
  logic write_w;

  // one address only; every other address reads as zero
  assign hit_w   = (mgmt_addr_i == anptx_pkg::NEXT_PAGE_TRANSMIT_ADDR);
  assign write_w = mgmt_write_i && hit_w;

  // ---------------------------------------------------------------
  // writable fields
  // ---------------------------------------------------------------

  logic              more_pages_reg;
  logic              more_pages_next;
  logic              message_page_reg;
  logic              message_page_next;
  logic              can_comply_reg;
  logic              can_comply_next;
  logic [CODE_W-1:0] code_field_reg;
  logic [CODE_W-1:0] code_field_next;

  // bits 14 and 11 of the write data have no destination at all, so a
  // careless write cannot disturb the reserved bit or the flip bit
  assign more_pages_next   = write_w ? flag_of(mgmt_wdata_i, anptx_pkg::MORE_PAGES_BIT)
                                     : more_pages_reg;
  assign message_page_next = write_w ? flag_of(mgmt_wdata_i, anptx_pkg::MESSAGE_PAGE_BIT)
                                     : message_page_reg;
  assign can_comply_next   = write_w ? flag_of(mgmt_wdata_i, anptx_pkg::CAN_COMPLY_BIT)
                                     : can_comply_reg;
  assign code_field_next   = write_w ? code_of(mgmt_wdata_i)
                                     : code_field_reg;

  // more pages: last page out of reset
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      more_pages_reg <= reset_bit(anptx_pkg::MORE_PAGES_BIT);
    end else begin
      more_pages_reg <= more_pages_next;
    end
  end

  // message page: set out of reset
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      message_page_reg <= reset_bit(anptx_pkg::MESSAGE_PAGE_BIT);
    end else begin
      message_page_reg <= message_page_next;
    end
  end

  // can comply: clear out of reset
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      can_comply_reg <= reset_bit(anptx_pkg::CAN_COMPLY_BIT);
    end else begin
      can_comply_reg <= can_comply_next;
    end
  end

  // code field: reset value taken whole from the reset word
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      code_field_reg <= code_of(RESET_VALUE);
    end else begin
      code_field_reg <= code_field_next;
    end
  end

  // ---------------------------------------------------------------
  // flip bit
  // ---------------------------------------------------------------

  logic flip_reg;
  logic flip_next;
  logic seed_flip_w;
  logic toggled_flip_w;

  // the base word seeds the flip bit; a base word and a next page in the
  // same cycle cannot both be on the link, so the base word wins
  assign seed_flip_w    = ~base_word_i[anptx_pkg::BASE_FLIP_BIT];
  assign toggled_flip_w = page_sent_i ? ~flip_reg : flip_reg;
  assign flip_next      = base_sent_i ? seed_flip_w : toggled_flip_w;

  // no base word seen yet: the flip bit starts from its reset value and still
  // toggles with page_sent_i; a user must send the base word first for the seed to mean anything
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      flip_reg <= reset_bit(anptx_pkg::FLIP_BIT);
    end else begin
      flip_reg <= flip_next;
    end
  end

  // ---------------------------------------------------------------
  // outgoing word and readback
  // ---------------------------------------------------------------

  logic [15:0] word_w;
  logic [15:0] rdata_next;
  logic [15:0] word_reg;
  logic [15:0] rdata_reg;

  assign word_w = compose_word(more_pages_reg, message_page_reg, can_comply_reg,
                               flip_reg, code_field_reg);

  // reads are registered: data stands one cycle after the address
  assign rdata_next = hit_w ? word_w : '0;

  // word lags the fields by one cycle; costs a cycle, keeps the link
  // side free of any path from the management bus
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      word_reg <= '0;
    end else begin
      word_reg <= word_w;
    end
  end

  // read data for any address, zero when not ours
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign next_page_word_o = word_reg;
  assign mgmt_rdata_o     = rdata_reg;

  // ---------------------------------------------------------------
  // next-page enable
  // ---------------------------------------------------------------

  // next pages only if both ends are able; the partner's ability is a
  // level, so dropping it withdraws the request at once
  assign next_pages_enable_o = more_pages_reg && partner_np_able_i;

endmodule // anptx_register

// ---- rtl/anptx_pkg.sv ----
package anptx_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [4:0]  NEXT_PAGE_TRANSMIT_ADDR  = 5'h07;
  localparam logic [15:0] NEXT_PAGE_TRANSMIT_RESET = 16'h2001;
  localparam int          MORE_PAGES_BIT           = 15;
  localparam int          RESERVED_BIT             = 14;
  localparam int          MESSAGE_PAGE_BIT         = 13;
  localparam int          CAN_COMPLY_BIT           = 12;
  localparam int          FLIP_BIT                 = 11;
  localparam int          CODE_MSB                 = 10;
  localparam int          CODE_WIDTH               = 11;
  // writable bits: more pages, message page, can comply, code field
  localparam logic [15:0] WRITE_MASK               = 16'hb7ff;
  // base link control word bit that seeds the first flip value
  localparam int          BASE_FLIP_BIT            = 11;
endpackage : anptx_pkg

// ---- sim/anptx_props.sv ----
`timescale 1ns/10ps
module anptx_props (
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic [4:0]  mgmt_addr_i,
  input wire logic        mgmt_write_i,
  input wire logic [15:0] mgmt_wdata_i,
  input wire logic [15:0] mgmt_rdata_o,
  input wire logic [15:0] base_word_i,
  input wire logic        base_sent_i,
  input wire logic        partner_np_able_i,
  input wire logic        page_sent_i,
  input wire logic        next_pages_enable_o,
  input wire logic [15:0] next_page_word_o
);
  localparam logic [4:0]  ADDR = 5'h07;
  localparam logic [15:0] MASK = 16'hb7ff;
  wire logic hit_w = (mgmt_addr_i == ADDR);
  wire logic wr_w  = mgmt_write_i && hit_w;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  property p_fd;
    wr_w ##1 !wr_w |=> ((next_page_word_o ^ $past(mgmt_wdata_i, 2)) & MASK) == 16'h0000;
  endproperty
  a_fd: assert property (p_fd) else $error("fields");
  property p_fl;
    page_sent_i && !base_sent_i |=> ##1 next_page_word_o[11] != $past(next_page_word_o[11]);
  endproperty
  a_fl: assert property (p_fl) else $error("flip");
  property p_seed;
    base_sent_i |=> ##1 next_page_word_o[11] == !$past(base_word_i[11], 2);
  endproperty
  a_seed: assert property (p_seed) else $error("flip seed");
  property p_rsv;
    !next_page_word_o[14] && !mgmt_rdata_o[14];
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit");
  property p_gate;
    !partner_np_able_i |-> !next_pages_enable_o;
  endproperty
  a_gate: assert property (p_gate) else $error("enable gate");
  property p_follow;
    partner_np_able_i && !$past(wr_w) |-> next_pages_enable_o == next_page_word_o[15];
  endproperty
  a_follow: assert property (p_follow) else $error("enable follow");
  property p_rd0;
    !hit_w |=> mgmt_rdata_o == 16'h0000;
  endproperty
  a_rd0: assert property (p_rd0) else $error("other address");
  property p_rdw;
    hit_w |=> mgmt_rdata_o == next_page_word_o;
  endproperty
  a_rdw: assert property (p_rdw) else $error("readback");
  property p_ign;
    wr_w && !base_sent_i && !page_sent_i |=> ##1
      next_page_word_o[11] == $past(next_page_word_o[11]);
  endproperty
  a_ign: assert property (p_ign) else $error("flip written");
  property p_cov_wr;
    wr_w;
  endproperty
  c_wr: cover property (p_cov_wr);
  property p_cov_seed;
    base_sent_i ##1 page_sent_i && !base_sent_i;
  endproperty
  c_seed: cover property (p_cov_seed);
  property p_cov_np;
    next_pages_enable_o && page_sent_i;
  endproperty
  c_np: cover property (p_cov_np);
endmodule // anptx_props
bind anptx_register anptx_props i_anptx_props (.*);

// ---- sim/anptx_sta_model.sv ----
`timescale 1ns/10ps
module anptx_sta_model (
  input  wire logic        clk_i,
  output logic      [4:0]  a_o = 5'h00,
  output logic             w_o = 1'b0,
  output logic      [15:0] d_o = 16'h0000
);
  // reserved bit 14 defaults to zero, so every write carries a zero there
  localparam logic [15:0] RESERVED_CLEAR = 16'hbfff;
  // called just after a falling edge; the request stands a whole cycle
  task automatic put(input logic [4:0] addr, input logic wr, input logic [15:0] data);
    a_o = addr;
    w_o = wr;
    d_o = data & RESERVED_CLEAR;
  endtask
endmodule // anptx_sta_model

// ---- sim/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
  // ---------------------------------------------------------------
  // bench state
  // ---------------------------------------------------------------
  localparam int CYCLE_LIMIT = 400;
  logic        clk_i       = 1'b0;
  logic        reset_i     = 1'b1;
  logic        w;
  logic        rv          = 1'b0;
  logic        rq          = 1'b0;
  logic        en;
  logic [4:0]  a;
  logic [15:0] d;
  logic [15:0] r;
  logic [15:0] word;
  logic [15:0] st          = anptx_pkg::NEXT_PAGE_TRANSMIT_RESET;
  logic [15:0] rdq[$];
  logic [15:0] wdq[$];
  logic        enq[$];
  logic [31:0] v           = 32'h0000_0000;
  int          error_cnt   = 0;
  int          checks_done = 0;
  int          seed        = 83;
  int          cyc         = 0;

  always #10 clk_i = ~clk_i;

  anptx_sta_model i_anptx_sta_model (
    .clk_i (clk_i),
    .a_o   (a),
    .w_o   (w),
    .d_o   (d)
  );

  anptx_register i_anptx_register (
    .clk_i               (clk_i),
    .reset_i             (reset_i),
    .mgmt_addr_i         (a),
    .mgmt_write_i        (w),
    .mgmt_wdata_i        (d),
    .mgmt_rdata_o        (r),
    .base_word_i         (v[15:0]),
    .base_sent_i         (v[6]),
    .partner_np_able_i   (v[9]),
    .page_sent_i         (v[8]),
    .next_pages_enable_o (en),
    .next_page_word_o    (word)
  );

  // ---------------------------------------------------------------
  // compare tasks
  // ---------------------------------------------------------------
  task automatic cmp_rd(input logic [15:0] e);
    checks_done++;
    if (r !== e) begin
      error_cnt++;
      $display("ERROR mgmt_rdata_o expected %h seen %h", e, r);
    end
  endtask

  task automatic cmp_word(input logic [15:0] e);
    checks_done++;
    if (word !== e) begin
      error_cnt++;
      $display("ERROR next_page_word_o expected %h seen %h", e, word);
    end
  endtask

  task automatic cmp_en(input logic e);
    checks_done++;
    if (en !== e) begin
      error_cnt++;
      $display("ERROR next_pages_enable_o expected %b seen %b", e, en);
    end
  endtask

  task close_out;
    if (error_cnt == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // watchers
  // ---------------------------------------------------------------
  // enable is combinational: looked at before the edge updates the fields
  always @(posedge clk_i) begin
    rq <= rv;
    if (enq.size() > 0) cmp_en(enq.pop_front());
  end

  always @(negedge clk_i) begin
    if (rq) begin
      cmp_rd(rdq.pop_front());
      cmp_word(wdq.pop_front());
    end
    cyc++;
    if (cyc > CYCLE_LIMIT) begin
      error_cnt++;
      close_out();
    end
  end

  // ---------------------------------------------------------------
  // stimulus
  // ---------------------------------------------------------------
  task automatic step;
    v = $random(seed);
    i_anptx_sta_model.put(v[4] ? 5'h07 : {1'b0, v[3:0]}, v[5], v[31:16]);
    rv = 1'b1;
    rdq.push_back((a == 5'h07) ? st : 16'h0000);
    wdq.push_back(st);
    enq.push_back(st[15] & v[9]);
    if (w && a == 5'h07) st = (d & 16'hb7ff) | (st & 16'h0800);
    if (v[6]) st[11] = ~v[11];
    else if (v[8]) st[11] = ~st[11];
  endtask

  initial begin
    repeat (2) @(negedge clk_i);
    reset_i = 1'b0;
    repeat (40) begin
      @(negedge clk_i);
      step();
    end
    // second reset in mid-run: fields must return to their reset value
    @(negedge clk_i);
    rv = 1'b0;
    v = 32'h0000_0000;
    i_anptx_sta_model.put(5'h00, 1'b0, 16'h0000);
    reset_i = 1'b1;
    repeat (2) @(negedge clk_i);
    reset_i = 1'b0;
    st = anptx_pkg::NEXT_PAGE_TRANSMIT_RESET;
    repeat (40) begin
      @(negedge clk_i);
      step();
    end
    @(negedge clk_i);
    rv = 1'b0;
    repeat (2) @(negedge clk_i);
    close_out();
  end
endmodule // tb_top
